// ===== core/msa_pkg.sv
package msa_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned FLASH_MS = 5000;  // fault flash length
  localparam int unsigned BLINK_MS = 250;   // half period of flashing
  localparam int unsigned FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
  localparam int unsigned MS_CYC = 1000 * CLK_MHZ;  // watchdog tick
  localparam logic [3:0] PWM_DIV = 4'hF;    // pwm step every 16 cycles
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] HIST_OFS = 8'h08;
  localparam logic [7:0] STATIC_OFS = 8'h0C;
  localparam logic [7:0] WDOG_OFS = 8'h10;
  localparam logic [7:0] KICK_OFS = 8'h14;
  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CTRL_COUPLE = 4;  // bus coupling fault message
  localparam int CTRL_STEPF = 5;   // step fault, write one pulse
  localparam int CTRL_CRCCLR = 6;  // clear checksum report
  localparam int CTRL_WDEN = 7;    // watchdog enable
  localparam logic [15:0] WDOG_RST = 16'h03E8;  // default 1000 ms
  // ---------------------------------------------------------------
  // display codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CODE_BOOT = 4'h0;
  localparam logic [3:0] CODE_SELF = 4'h1;
  localparam logic [3:0] CODE_SBINIT = 4'h5;
  localparam logic [3:0] CODE_ACTIVE = 4'h9;
  localparam logic [3:0] CODE_ADDR = 4'hA;
  localparam logic [3:0] CODE_BUS = 4'hB;
  localparam logic [3:0] CODE_PAR = 4'hC;
  localparam logic [3:0] CODE_RUNT = 4'hD;
  localparam logic [3:0] CODE_EXC = 4'hE;
  localparam logic [3:0] CODE_TEMP = 4'hF;
  // ---------------------------------------------------------------
  // restart sequencing phases
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PH_RUN, PH_HOLD, PH_RESTART} msa_phase_t;
endpackage

// ===== core/msa_timer.sv
// down counter that expires after a loaded number of ticks
module msa_timer
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic stop,
  input wire logic tick,
  input wire logic [31:0] loadVal,
  output logic running,
  output logic expired
);
  import msa_pkg::*;

  logic [31:0] count;  // remaining ticks
  wire lastTick = running && tick && (count <= 32'h00000001);

  // -------------------------------------------------------------
  // counting process
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count <= 32'h00000000;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (stop)
    begin
      // abort without expiry
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (start)
    begin
      count <= loadVal;
      running <= 1'b1;
      expired <= 1'b0;
    end
    else
    begin
      expired <= lastTick;
      if (lastTick)
        running <= 1'b0;
      else if (running && tick)
        count <= count - 32'h00000001;
    end
  end
endmodule

// ===== core/msa_annunciator.sv
// Behaviour
// - station or processing fault lights both red lamps
// - red lamps lit until code nine reached
// - host coupling fault message lights red lamps
// - halt lamp follows processor halt
// - run lamp lit, duty follows workload
// - link lamp follows ethernet link
// - traffic lamp lit on send or receive
// - single hex digit shows sixteen codes
// - faulted startup step flashes about five seconds
// - watchdog expiry forces a restart
// - codes zero to five are startup steps
// - codes six to nine are connect states
// - address and bus errors show A, B, restart
// - runtime and exception errors show D, E, restart
// - parity restarts, checksum only reports, code C
// - temperature fault shows code F
// - history flags latch until module restart
// - static flags follow their cause
// - code nine extinguishes both red lamps
//
// The plain strobed port and the register addresses were decided locally.
module msa_annunciator
#(
  parameter int unsigned FLASH_CYCLES = msa_pkg::FLASH_CYC,
  parameter int unsigned BLINK_CYCLES = msa_pkg::BLINK_CYC,
  parameter int unsigned MS_CYCLES = msa_pkg::MS_CYC
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic stationBusFault,
  input wire logic procSectionFault,
  input wire logic procHalted,
  input wire logic procActive,
  input wire logic [7:0] procLoad,
  input wire logic ethLink,
  input wire logic ethTx,
  input wire logic ethRx,
  input wire logic addrError,
  input wire logic busError,
  input wire logic parityError,
  input wire logic checksumError,
  input wire logic runtimeError,
  input wire logic exceptionError,
  input wire logic tempFault,
  input wire logic [7:0] histCause,
  input wire logic [7:0] staticCause,
  output logic stationDisturbanceLamp,
  output logic moduleDisturbanceLamp,
  output logic processorHaltLamp,
  output logic runLamp,
  output logic networkLinkLamp,
  output logic trafficLamp,
  output logic [3:0] statusDigit,
  output logic statusDigitLit,
  output logic moduleRestart
);
  import msa_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // true for the transient startup steps 1..5
  function automatic logic isStep(input logic [3:0] code);
    isStep = (code >= CODE_SELF) && (code <= CODE_SBINIT);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  msa_phase_t phase;          // restart sequencing
  logic [3:0] stateCode;      // normal operating code from firmware
  logic couplingFault;        // host set coupling fault message
  logic wdogEnable;           // watchdog armed
  logic [15:0] wdogTime;      // watchdog time in ms
  logic errActive;            // restarting error latched
  logic [3:0] errCode;        // latched error code
  logic crcFlag;              // checksum report, no restart
  logic [7:0] histFlags;      // latched history flags
  logic [7:0] staticFlags;    // following static flags
  logic [31:0] blinkCnt;      // blink half period counter
  logic blinkOn;              // blink phase
  logic [3:0] pwmDiv;         // pwm step divider
  logic [7:0] pwmCnt;         // pwm ramp
  logic flashRun;             // flash timer running
  logic flashDone;            // flash timer expired
  logic wdogRun;              // watchdog running
  logic wdogDone;             // watchdog expired
  logic [31:0] msCnt;         // millisecond divider
  logic msTick;               // one cycle per ms

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire wrCtrl = regWr && (regAddr == CTRL_OFS);
  wire wrWdog = regWr && (regAddr == WDOG_OFS);
  wire wrKick = regWr && (regAddr == KICK_OFS);
  wire inRestart = (phase == PH_RESTART);
  wire stepFaultReq = wrCtrl && regWrData[CTRL_STEPF] && isStep(regWrData[3:0]);
  wire crcClear = wrCtrl && regWrData[CTRL_CRCCLR];

  // ---------------------------------------------------------------
  // error selection
  // ---------------------------------------------------------------
  wire restartErr = addrError | busError | parityError | runtimeError | exceptionError;
  wire [3:0] errSel = addrError ? CODE_ADDR :
                      busError ? CODE_BUS :
                      parityError ? CODE_PAR :
                      runtimeError ? CODE_RUNT :
                      CODE_EXC;

  // ---------------------------------------------------------------
  // restart sequencing decisions
  // ---------------------------------------------------------------
  wire takeErr = (phase == PH_RUN) && restartErr;
  wire flashStart = (phase == PH_RUN) && (restartErr || stepFaultReq);
  wire restartNow = ((phase == PH_HOLD) && flashDone) ||
                    ((phase == PH_RUN) && wdogDone && !restartErr);
  msa_phase_t next_phase;
  assign next_phase = restartNow ? PH_RESTART :
                      flashStart ? PH_HOLD :
                      inRestart ? PH_RUN : phase;

  // ---------------------------------------------------------------
  // next values of software state
  // ---------------------------------------------------------------
  wire [3:0] next_stateCode = inRestart ? CODE_BOOT : wrCtrl ? regWrData[3:0] : stateCode;
  wire next_crcFlag = checksumError | (crcFlag & ~(crcClear | inRestart));
  wire [7:0] next_histFlags = inRestart ? histCause : (histFlags | histCause);
  wire wdogStart = wdogEnable && (wrKick || (phase == PH_RUN && !wdogRun));

  // ---------------------------------------------------------------
  // display and lamp selection
  // ---------------------------------------------------------------
  wire [3:0] shownCode = errActive ? errCode :
                         crcFlag ? CODE_PAR :
                         tempFault ? CODE_TEMP :
                         stateCode;
  wire flashing = (phase == PH_HOLD);
  wire redLamp = stationBusFault | procSectionFault |
                 couplingFault |
                 (stateCode != CODE_ACTIVE);
  wire blinkWrap = (blinkCnt >= BLINK_CYCLES - 1);
  wire msWrap = (msCnt >= MS_CYCLES - 1);
  wire pwmTick = (pwmDiv == PWM_DIV);

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  msa_timer flashTimer
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(flashStart),
    .stop(inRestart),
    .tick(1'b1),
    .loadVal(FLASH_CYCLES),
    .running(flashRun),
    .expired(flashDone)
  );

  msa_timer wdogTimer
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(wdogStart),
    .stop(inRestart || !wdogEnable || phase == PH_HOLD),
    .tick(msTick),
    .loadVal({16'h0000, wdogTime}),
    .running(wdogRun),
    .expired(wdogDone)
  );

  // ---------------------------------------------------------------
  // sequencing and error latch
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase <= PH_RUN;
      errActive <= 1'b0;
      errCode <= CODE_BOOT;
      moduleRestart <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      moduleRestart <= restartNow;
      if (takeErr)
      begin
        // first error wins until restart
        errActive <= 1'b1;
        errCode <= errSel;
      end
      else if (inRestart)
        errActive <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // software state and flags
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stateCode <= CODE_BOOT;
      couplingFault <= 1'b0;
      wdogEnable <= 1'b0;
      wdogTime <= WDOG_RST;
      crcFlag <= 1'b0;
      histFlags <= 8'h00;
      staticFlags <= 8'h00;
    end
    else
    begin
      stateCode <= next_stateCode;
      crcFlag <= next_crcFlag;
      histFlags <= next_histFlags;
      staticFlags <= staticCause;
      if (wrCtrl)
      begin
        couplingFault <= regWrData[CTRL_COUPLE];
        wdogEnable <= regWrData[CTRL_WDEN];
      end
      if (wrWdog)
        wdogTime <= regWrData[15:0];
    end
  end

  // ---------------------------------------------------------------
  // dividers: blink, millisecond tick, pwm step
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      blinkCnt <= 32'h00000000;
      blinkOn <= 1'b1;
      msCnt <= 32'h00000000;
      msTick <= 1'b0;
      pwmDiv <= 4'h0;
      pwmCnt <= 8'h00;
    end
    else
    begin
      blinkCnt <= blinkWrap ? 32'h00000000 : blinkCnt + 32'h00000001;
      if (blinkWrap)
        blinkOn <= ~blinkOn;
      msCnt <= msWrap ? 32'h00000000 : msCnt + 32'h00000001;
      msTick <= msWrap;
      pwmDiv <= pwmDiv + 4'h1;
      if (pwmTick)
        pwmCnt <= pwmCnt + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // lamp and display outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stationDisturbanceLamp <= 1'b1;
      moduleDisturbanceLamp <= 1'b1;
      processorHaltLamp <= 1'b0;
      runLamp <= 1'b0;
      networkLinkLamp <= 1'b0;
      trafficLamp <= 1'b0;
      statusDigit <= CODE_BOOT;
      statusDigitLit <= 1'b1;
    end
    else
    begin
      stationDisturbanceLamp <= redLamp;
      moduleDisturbanceLamp <= redLamp;
      processorHaltLamp <= procHalted;
      runLamp <= procActive && (pwmCnt <= procLoad);
      networkLinkLamp <= ethLink;
      trafficLamp <= ethTx | ethRx;
      statusDigit <= shownCode;
      statusDigitLit <= flashing ? blinkOn : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  wire [31:0] ctrlView = {24'h000000, wdogEnable, 2'b00, couplingFault, stateCode};
  wire [31:0] statView = {20'h00000, phase, wdogRun, flashRun, crcFlag, tempFault,
                          errActive, flashing, shownCode};
  wire [31:0] rdMux = (regAddr == CTRL_OFS) ? ctrlView :
                      (regAddr == STAT_OFS) ? statView :
                      (regAddr == HIST_OFS) ? {24'h000000, histFlags} :
                      (regAddr == STATIC_OFS) ? {24'h000000, staticFlags} :
                      (regAddr == WDOG_OFS) ? {16'h0000, wdogTime} : 32'h00000000;

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      regRdData <= 32'h00000000;
    else
      regRdData <= regRd ? rdMux : 32'h00000000;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_fault_lamps: assert property ((stationBusFault || procSectionFault) |=>
                                  stationDisturbanceLamp && moduleDisturbanceLamp)
    else $error("fault did not light red lamps");
  a_not_active_lamps: assert property ((stateCode != CODE_ACTIVE) |=> stationDisturbanceLamp)
    else $error("red lamp dark before active state");
  a_coupling_lamp: assert property (couplingFault |=> moduleDisturbanceLamp)
    else $error("coupling fault did not light lamp");
  a_halt_lamp: assert property (##1 processorHaltLamp == $past(procHalted))
    else $error("halt lamp mismatch");
  a_link_traffic: assert property (##1 networkLinkLamp == $past(ethLink) &&
                                   trafficLamp == $past(ethTx || ethRx))
    else $error("network lamps mismatch");
  a_active_dark: assert property ((stateCode == CODE_ACTIVE && !stationBusFault && !procSectionFault
                                   && !couplingFault) |=> !stationDisturbanceLamp)
    else $error("red lamp lit in active state");
  a_error_shown: assert property (takeErr |=> (phase == PH_HOLD && errActive)
                                  ##1 statusDigit == $past(errSel, 2))
    else $error("error code not shown while holding");
  a_flash_restart: assert property ((phase == PH_HOLD && flashDone) |=>
                                    moduleRestart && phase == PH_RESTART)
    else $error("flash expiry did not restart");
  a_crc_norestart: assert property ((phase == PH_RUN && !restartErr && !wdogDone) |=> !moduleRestart)
    else $error("restart without cause");
  a_hist_clear: assert property (inRestart |=> histFlags == $past(histCause))
    else $error("history not cleared on restart");
  a_static_follow: assert property (##1 staticFlags == $past(staticCause))
    else $error("static flags do not follow cause");
endmodule

// ===== sim/msa_host_model.sv
// -------------------------------------------------------------
// host side register master
// -------------------------------------------------------------
module msa_host_model
(
  input wire logic ref_clk,
  output logic [7:0] regAddr,
  output logic [31:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [31:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial
  begin
    regAddr = 8'h00;
    regWrData = 32'h00000000;
    regWr = 1'h0;
    regRd = 1'h0;
  end

  // one cycle write, then scramble the released lines
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge ref_clk);
    regWr <= 1'h0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask

  // one cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge ref_clk);
    regRd <= 1'h0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask

  // coupling fault message with a state code beside it
  task automatic couple(input logic on, input logic [3:0] code);
    wr(8'h00, {27'h0000000, on, code});
  endtask
endmodule

// ===== sim/tb_msa_annunciator.sv
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errCount++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, e); end end
module tb_msa_annunciator import msa_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned FLASH = 40;
  localparam logic [3:0] ERRC [5] = '{CODE_ADDR, CODE_BUS, CODE_PAR, CODE_RUNT, CODE_EXC};
  logic ref_clk = 1'h0;
  logic nrst, regWr, regRd, procHalted, procActive, ethLink, ethTx, ethRx, checksumError, tempFault;
  logic stationBusFault, procSectionFault, addrError, busError, parityError, runtimeError, exceptionError;
  logic [1:0] faultVec;
  logic [4:0] errVec;
  logic [7:0] regAddr, procLoad, histCause, staticCause;
  logic [31:0] regWrData, regRdData, rdv;
  logic stationDisturbanceLamp, moduleDisturbanceLamp, processorHaltLamp, runLamp, networkLinkLamp;
  logic trafficLamp, statusDigitLit, moduleRestart, seen0, seen1;
  logic [3:0] statusDigit;
  int errCount, compares, cycles, restarts, n;
  // -------------------------------------------------------------
  // fault and error vectors fan out to the inputs
  // -------------------------------------------------------------
  assign {procSectionFault, stationBusFault} = faultVec;
  assign {exceptionError, runtimeError, parityError, busError, addrError} = errVec;

  always #4 ref_clk = ~ref_clk;

  // cycle ceiling and restart pulse counter
  always @(posedge ref_clk)
  begin
    cycles++;
    if (moduleRestart === 1'h1)
      restarts++;
    if (cycles == 5000)
    begin
      errCount++;
      reportAndStop();
    end
  end

  msa_host_model i_host (.ref_clk, .regAddr, .regWrData, .regWr, .regRd, .regRdData);

  msa_annunciator #(.FLASH_CYCLES(FLASH), .BLINK_CYCLES(4), .MS_CYCLES(4)) i_dut (
    .ref_clk, .nrst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .stationBusFault,
    .procSectionFault, .procHalted, .procActive, .procLoad, .ethLink, .ethTx, .ethRx, .addrError,
    .busError, .parityError, .checksumError, .runtimeError, .exceptionError, .tempFault, .histCause,
    .staticCause, .stationDisturbanceLamp, .moduleDisturbanceLamp, .processorHaltLamp, .runLamp,
    .networkLinkLamp, .trafficLamp, .statusDigit, .statusDigitLit, .moduleRestart);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  // wait for a restart pulse, bounded
  task automatic waitRestart(input int lim, output int c);
    c = 0;
    while (moduleRestart !== 1'h1 && c < lim)
    begin
      tick(1);
      c++;
    end
  endtask

  // run lamp lit cycles over a 64 cycle window
  task automatic litCount(output int c);
    c = 0;
    repeat (64)
    begin
      tick(1);
      c += (runLamp === 1'h1);
    end
  endtask

  task automatic reportAndStop();
    $display("compares=%0d errors=%0d", compares, errCount);
    if (errCount == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    {nrst, procHalted, procActive, ethLink, ethTx, ethRx, checksumError, tempFault} = 8'h00;
    {faultVec, errVec, procLoad, histCause, staticCause} = 31'h00000000;
    tick(5);
    `CHK({moduleDisturbanceLamp, stationDisturbanceLamp, statusDigit}, 6'h30) // reset lamps
    `CHK({statusDigitLit, moduleRestart}, 2'h2)
    @(posedge ref_clk);
    nrst <= 1'h1;
    // state codes and red lamps
    for (int c = 0; c < 10; c++)
    begin
      i_host.wr(CTRL_OFS, c);
      tick(2);
      `CHK(statusDigit, 4'(c))
      `CHK(moduleDisturbanceLamp, 1'(c != 9))
      `CHK(stationDisturbanceLamp, 1'(c != 9))
    end
    $display("test codes done");
    // disturbance causes with code nine
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      faultVec <= 2'h1 << i;
      tick(3);
      `CHK({moduleDisturbanceLamp, stationDisturbanceLamp}, 2'h3)
      @(posedge ref_clk);
      faultVec <= 2'h0;
      tick(3);
      `CHK(stationDisturbanceLamp, 1'h0)
    end
    i_host.couple(1'h1, CODE_ACTIVE);
    tick(2);
    `CHK({moduleDisturbanceLamp, stationDisturbanceLamp}, 2'h3)
    i_host.couple(1'h0, CODE_ACTIVE);
    tick(2);
    `CHK(moduleDisturbanceLamp, 1'h0)
    $display("test red lamps done");
    // halt, link and traffic lamps
    @(posedge ref_clk);
    {procHalted, ethLink, ethTx} <= 3'h7;
    tick(2);
    `CHK({processorHaltLamp, networkLinkLamp, trafficLamp}, 3'h7)
    @(posedge ref_clk);
    {procHalted, ethLink, ethTx, ethRx} <= 4'h1;
    tick(2);
    `CHK({processorHaltLamp, networkLinkLamp, trafficLamp}, 3'h1)
    @(posedge ref_clk);
    ethRx <= 1'h0;
    tick(2);
    `CHK(trafficLamp, 1'h0)
    // run lamp brightness
    @(posedge ref_clk);
    {procActive, procLoad} <= 9'h1FF;
    litCount(n);
    `CHK(n, 64) // full load
    @(posedge ref_clk);
    procLoad <= 8'h00;
    litCount(n);
    `CHK(n < 64, 1'h1) // light load
    @(posedge ref_clk);
    procActive <= 1'h0;
    litCount(n);
    `CHK(n, 0) // idle
    $display("test lamps done");
    // temperature and checksum reports
    @(posedge ref_clk);
    tempFault <= 1'h1;
    tick(3);
    `CHK(statusDigit, CODE_TEMP)
    @(posedge ref_clk);
    tempFault <= 1'h0;
    checksumError <= 1'h1;
    @(posedge ref_clk);
    checksumError <= 1'h0;
    tick(3);
    `CHK(statusDigit, CODE_PAR)
    n = restarts;
    tick(FLASH + 10);
    `CHK(restarts, n) // no restart
    i_host.wr(CTRL_OFS, 32'h00000049);
    tick(2);
    `CHK(statusDigit, CODE_ACTIVE)
    $display("test reports done");
    // history and static flags, unmapped reads
    @(posedge ref_clk);
    histCause <= 8'h01;
    staticCause <= 8'h0C;
    @(posedge ref_clk);
    histCause <= 8'h00;
    tick(2);
    i_host.rd(HIST_OFS, rdv);
    `CHK(rdv, 32'h00000001) // latched
    i_host.rd(STATIC_OFS, rdv);
    `CHK(rdv, 32'h0000000C)
    @(posedge ref_clk);
    staticCause <= 8'h00;
    tick(2);
    i_host.rd(STATIC_OFS, rdv);
    `CHK(rdv, 32'h00000000)
    i_host.rd(8'h40, rdv);
    `CHK(rdv, 32'h00000000)
    $display("test flags done");
    // restarting errors
    for (int i = 0; i < 5; i++)
    begin
      i_host.wr(CTRL_OFS, 32'h00000009);
      @(posedge ref_clk);
      errVec <= 5'h01 << i;
      @(posedge ref_clk);
      errVec <= 5'h00;
      tick(3);
      `CHK(statusDigit, ERRC[i])
      waitRestart(FLASH + 10, n);
      `CHK({moduleRestart, n >= FLASH - 8}, 2'h3)
      tick(2);
      `CHK({moduleDisturbanceLamp, statusDigit}, 5'h10)
    end
    i_host.rd(HIST_OFS, rdv);
    `CHK(rdv, 32'h00000000) // cleared by restart
    $display("test errors done");
    // faulted startup step flashes
    i_host.wr(CTRL_OFS, 32'h00000023);
    tick(3);
    `CHK(statusDigit, 4'h3)
    // status view: hold phase, flash timer running, flashing, code 3
    i_host.rd(STAT_OFS, rdv);
    `CHK(rdv, 32'h00000513)
    {seen0, seen1} = 2'h0;
    repeat (8)
    begin
      tick(1);
      seen0 |= (statusDigitLit === 1'h0);
      seen1 |= (statusDigitLit === 1'h1);
    end
    `CHK({seen0, seen1}, 2'h3) // flashing
    waitRestart(FLASH + 10, n);
    `CHK({moduleRestart, n >= FLASH - 18}, 2'h3)
    $display("test step fault done");
    // watchdog kicked, then left to expire
    i_host.wr(WDOG_OFS, 32'h00000002);
    i_host.wr(CTRL_OFS, 32'h00000089);
    n = restarts;
    repeat (12) i_host.wr(KICK_OFS, 32'h00000000);
    `CHK(restarts, n) // serviced
    waitRestart(30, n);
    `CHK(moduleRestart, 1'h1) // expiry
    i_host.wr(CTRL_OFS, 32'h00000009);
    $display("test watchdog done");
    reportAndStop();
  end
endmodule
